/* rss_regs.vh */
// Register offsets, field positions, reset values and timing counts of the reset sequencer.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`ifndef RSS_REGS_VH
`define RSS_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSS_OFF_BROWNOUT_CONTROL 12'h000
`define RSS_OFF_POWER_CONTROL 12'h004
`define RSS_OFF_STATUS 12'h008
`define RSS_OFF_CONFIG 12'h00C
`define RSS_OFF_RESET_PC 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSS_BIT_SW_BOR_EN 7
`define RSS_BIT_BOR_RDY 0
`define RSS_BIT_STK_OVF 7
`define RSS_BIT_STK_UNF 6
`define RSS_BIT_PIN_RST 3
`define RSS_BIT_RST_INSTR 2
`define RSS_BIT_POR 1
`define RSS_BIT_BOR 0
`define RSS_BIT_TIMEOUT 4
`define RSS_BIT_POWERDOWN 3

// ----------------------------------------
// Brown-out modes
// ----------------------------------------
`define RSS_BOR_OFF 2'b00
`define RSS_BOR_SW 2'b01
`define RSS_BOR_NOSLEEP 2'b10
`define RSS_BOR_ON 2'b11

// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define RSS_PCON_MASK 8'hCF
`define RSS_RESET_VECTOR 15'h0000
`define RSS_IRQ_VECTOR 15'h0004

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSS_CLK_HZ 40000000
`define RSS_POWERUP_TIMER_MS 64
`define RSS_POWERUP_TIMER_CYCLES ((`RSS_CLK_HZ / 1000) * `RSS_POWERUP_TIMER_MS)
`define RSS_FILT_CYCLES 8

`endif

/* rss_filter.v */
// Glitch filter for the external reset pin.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ps
module rss_filter #(
    parameter LEN = 8
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire pin_i,
    output reg level_o
);

    reg [7:0] cnt_ff;

    // Level changes only after LEN stable cycles
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= 8'h00;
            level_o <= 1'b1;
        end
        else if (pin_i == level_o)
        begin
            cnt_ff <= 8'h00;
        end
        else if (cnt_ff == LEN[7:0] - 8'h01)
        begin
            cnt_ff <= 8'h00;
            level_o <= pin_i;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

endmodule

/* rss_top.v */
// Reset source sequencer: brown-out modes, reset pin, reset causes, start-up gating, APB registers.
// Assumes synchronous analog inputs, configuration bits stable after reset, one 40 MHz clock.
`timescale 1ns/1ps
`include "rss_regs.vh"

// What this block does
// - Mode 10: detector on awake, start waits ready
// - Mode 10: off in sleep, wake waits ready
// - Mode 01: software bit enables detector
// - Mode 01: start-up never waits for detector
// - Software mode: protect once ready, report ready
// - Software mode: sleep leaves protection unchanged
// - Software enable bit 7 resets 1, read/write
// - Ready bit 0 shows detector active and ready
// - Bits 6..1 read zero, writes ignored
// - Pin reset off only if both enables 0
// - Enabled pin held low holds reset
// - Short low pin pulses filtered out
// - Disabled pin is input, software pull-up
// - Watchdog timeout resets, clears timeout bit, clears powerdown bit only in sleep
// - Reset instruction resets, clears its flag
// - Stack fault resets when enabled, sets flag
// - Programming exit acts as power-on reset
// - Run waits timer, oscillator, pin release
// - Timers run regardless of pin state
// - Power-on and brown-out load documented values
// - Pin, watchdog, wake values as documented
// - Interrupt wake with enable vectors to 0004h
// - Mode 11: always on, start waits ready
// - Enabled power-up timer holds 64 ms
module rss_top #(
    parameter POWERUP_TIMER_CYCLES = `RSS_POWERUP_TIMER_CYCLES,
    parameter FILT_CYCLES = `RSS_FILT_CYCLES
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [1:0] brownout_mode_cfg_i,
    input wire ext_reset_pin_enable_i,
    input wire low_voltage_prog_enable_i,
    input wire stack_fault_reset_enable_i,
    input wire powerup_timer_enable_n_i,
    input wire ext_reset_pin_i,
    input wire por_i,
    input wire bor_low_i,
    input wire bor_ready_i,
    input wire ost_done_i,
    input wire prog_exit_i,
    input wire sleep_i,
    input wire wake_irq_i,
    input wire wake_wdt_i,
    input wire global_irq_enable_i,
    input wire wdt_timeout_i,
    input wire reset_instr_i,
    input wire stack_over_i,
    input wire stack_under_i,
    input wire sw_pullup_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg core_reset_o,
    output reg bor_enable_o,
    output reg wake_hold_o,
    output reg gpio_in_o,
    output reg pullup_en_o,
    output reg [14:0] pc_load_o,
    output reg pc_load_valid_o
);

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam ST_POR = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam ST_HOLD = 2'd3;

    reg [1:0] state_ff, nxt_state;
    reg [31:0] powerup_timer_cnt_ff;
    reg sw_bor_en_ff;
    reg [7:0] pcon_ff;
    reg timeout_ff, powerdown_ff;
    reg pending_pc_ff;
    reg wake_ff;
    wire pin_filt;
    wire pin_fn_en;
    wire det_active;
    wire need_ready;
    wire startup_ok;
    wire pin_reset;
    wire stk_reset;
    wire bus_wr, bus_rd, addr_ok;
    wire [7:0] pcon_wr;

    // Pin filter sits ahead of the reset path
    rss_filter #(.LEN(FILT_CYCLES)) u_filt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(ext_reset_pin_i),
        .level_o(pin_filt)
    );

    // ----------------------------------------
    // Detector mode decode
    // ----------------------------------------
    function det_on;
        input [1:0] mode;
        input sw_en;
        input asleep;
        begin
            case (mode)
                `RSS_BOR_ON: det_on = 1'b1;
                `RSS_BOR_NOSLEEP: det_on = ~asleep;
                `RSS_BOR_SW: det_on = sw_en;
                default: det_on = 1'b0;
            endcase
        end
    endfunction

    // A pending wake turns a mode 10 detector back on, else it could never get ready
    wire wake_req = wake_irq_i | wake_wdt_i;
    // Mode 10 wake is held off until the detector reports ready
    wire wake_wait = (brownout_mode_cfg_i == `RSS_BOR_NOSLEEP) & ~bor_ready_i;
    assign det_active = det_on(brownout_mode_cfg_i, sw_bor_en_ff, sleep_i & ~wake_req);
    // Only hardware-enabled modes gate start-up on the detector
    assign need_ready = brownout_mode_cfg_i[1];
    assign pin_fn_en = ext_reset_pin_enable_i | low_voltage_prog_enable_i;
    assign pin_reset = pin_fn_en & ~pin_filt;
    assign stk_reset = stack_fault_reset_enable_i & (stack_over_i | stack_under_i);
    // Timers counted independently of the pin; only release waits for it
    assign startup_ok = (powerup_timer_enable_n_i || powerup_timer_cnt_ff >= POWERUP_TIMER_CYCLES) && ost_done_i
                        && (!need_ready || (bor_ready_i && !bor_low_i));

    // Brown-out trips reset only while the detector is active and ready
    wire bor_trip = det_active & bor_ready_i & bor_low_i;
    wire por_evt = por_i | prog_exit_i;

    // ----------------------------------------
    // Start-up state machine
    // ----------------------------------------
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR: nxt_state = ST_WAIT;
            ST_WAIT:
            begin
                if (startup_ok && !pin_reset)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (pin_reset || wdt_timeout_i || reset_instr_i || stk_reset)
                    nxt_state = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!pin_reset)
                    nxt_state = ST_RUN;
            end
            default: nxt_state = ST_POR;
        endcase
        if (por_evt || bor_trip)
            nxt_state = ST_POR;
    end

    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            state_ff <= ST_POR;
        else
            state_ff <= nxt_state;
    end

    // Power-up timer restarts on every power-on or brown-out event
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i || por_evt || bor_trip)
            powerup_timer_cnt_ff <= 32'h0;
        else if (state_ff == ST_WAIT && powerup_timer_cnt_ff < POWERUP_TIMER_CYCLES)
            powerup_timer_cnt_ff <= powerup_timer_cnt_ff + 32'h1;
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign bus_wr = psel_i & penable_i & pwrite_i & pready_o;
    assign bus_rd = psel_i & penable_i & ~pwrite_i;
    assign addr_ok = (paddr_i == `RSS_OFF_BROWNOUT_CONTROL) || (paddr_i == `RSS_OFF_POWER_CONTROL)
                     || (paddr_i == `RSS_OFF_STATUS) || (paddr_i == `RSS_OFF_CONFIG)
                     || (paddr_i == `RSS_OFF_RESET_PC);
    assign pcon_wr = pwdata_i[7:0] & `RSS_PCON_MASK;

    // One wait state, answer in the second access cycle
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end
        else if (psel_i && penable_i && !pready_o)
        begin
            pready_o <= 1'b1;
            pslverr_o <= ~addr_ok;
            prdata_o <= 32'h0;
            if (bus_rd)
            begin
                case (paddr_i)
                    `RSS_OFF_BROWNOUT_CONTROL:
                        prdata_o <= {24'h0, sw_bor_en_ff, 6'h00, det_active & bor_ready_i};
                    `RSS_OFF_POWER_CONTROL: prdata_o <= {24'h0, pcon_ff};
                    `RSS_OFF_STATUS: prdata_o <= {27'h0, timeout_ff, powerdown_ff, 1'b0, state_ff};
                    `RSS_OFF_CONFIG:
                        prdata_o <= {26'h0, pin_fn_en, need_ready, brownout_mode_cfg_i, 1'b0, det_active};
                    `RSS_OFF_RESET_PC: prdata_o <= {17'h0, pc_load_o};
                    default: prdata_o <= 32'h0;
                endcase
            end
        end
        else
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Brown-out control register
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i || por_evt || bor_trip)
            sw_bor_en_ff <= 1'b1;
        else if (bus_wr && paddr_i == `RSS_OFF_BROWNOUT_CONTROL)
            sw_bor_en_ff <= pwdata_i[`RSS_BIT_SW_BOR_EN];
    end

    // ----------------------------------------
    // Reset cause flags, hardware wins over software
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i || por_evt)
        begin
            pcon_ff <= 8'h0C;
            timeout_ff <= 1'b1;
            powerdown_ff <= 1'b1;
        end
        else if (bor_trip)
        begin
            pcon_ff <= {2'b00, 2'b00, 2'b11, pcon_ff[`RSS_BIT_POR], 1'b0};
            timeout_ff <= 1'b1;
            powerdown_ff <= 1'b1;
        end
        else
        begin
            if (bus_wr && paddr_i == `RSS_OFF_POWER_CONTROL)
                pcon_ff <= pcon_wr;
            if (state_ff == ST_RUN && pin_reset)
            begin
                pcon_ff[`RSS_BIT_PIN_RST] <= 1'b0;
                if (sleep_i)
                begin
                    timeout_ff <= 1'b1;
                    powerdown_ff <= 1'b0;
                end
            end
            if (state_ff == ST_RUN && reset_instr_i)
                pcon_ff[`RSS_BIT_RST_INSTR] <= 1'b0;
            if (state_ff == ST_RUN && stk_reset && stack_over_i)
                pcon_ff[`RSS_BIT_STK_OVF] <= 1'b1;
            if (state_ff == ST_RUN && stk_reset && stack_under_i)
                pcon_ff[`RSS_BIT_STK_UNF] <= 1'b1;
            if (state_ff == ST_RUN && wdt_timeout_i)
            begin
                timeout_ff <= 1'b0;
                if (sleep_i)
                    powerdown_ff <= 1'b0;
            end
            else if (sleep_i && wake_irq_i)
            begin
                timeout_ff <= 1'b1;
                powerdown_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Program counter load and outputs
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pc_load_o <= `RSS_RESET_VECTOR;
            pc_load_valid_o <= 1'b0;
            pending_pc_ff <= 1'b1;
            wake_ff <= 1'b0;
        end
        else
        begin
            pc_load_valid_o <= 1'b0;
            wake_ff <= 1'b0;
            if (nxt_state != ST_RUN)
                pending_pc_ff <= 1'b1;
            if (state_ff != ST_RUN && nxt_state == ST_RUN && pending_pc_ff)
            begin
                pc_load_o <= `RSS_RESET_VECTOR;
                pc_load_valid_o <= 1'b1;
                pending_pc_ff <= 1'b0;
            end
            else if (state_ff == ST_RUN && sleep_i && wake_irq_i && global_irq_enable_i && !wdt_timeout_i
                     && !wake_wait)
            begin
                // PC + 1 runs first in the core, then it jumps here
                pc_load_o <= `RSS_IRQ_VECTOR;
                pc_load_valid_o <= 1'b1;
            end
            else if (state_ff == ST_RUN && sleep_i && (wake_wdt_i || wake_irq_i))
                wake_ff <= 1'b1;
        end
    end

    // Register every pin-facing output
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            core_reset_o <= 1'b1;
            bor_enable_o <= 1'b0;
            wake_hold_o <= 1'b0;
            gpio_in_o <= 1'b0;
            pullup_en_o <= 1'b1;
        end
        else
        begin
            core_reset_o <= (nxt_state != ST_RUN);
            bor_enable_o <= det_active;
            // Mode 10 wakes only after the detector is ready again
            wake_hold_o <= wake_wait;
            gpio_in_o <= pin_fn_en ? 1'b0 : ext_reset_pin_i;
            pullup_en_o <= pin_fn_en ? 1'b1 : sw_pullup_i;
        end
    end

endmodule

/* rss_top_props.sv */
// Port-level checker of the reset sequencer.
// Assumes it is bound to rss_top and sees only that module's ports.
`timescale 1ns/1ps
module rss_top_props #(
    parameter POWERUP_TIMER_CYCLES = 20,
    parameter FILT_CYCLES = 8
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [1:0] brownout_mode_cfg_i,
    input wire ext_reset_pin_enable_i,
    input wire low_voltage_prog_enable_i,
    input wire stack_fault_reset_enable_i,
    input wire ext_reset_pin_i,
    input wire por_i,
    input wire bor_low_i,
    input wire bor_ready_i,
    input wire ost_done_i,
    input wire prog_exit_i,
    input wire sleep_i,
    input wire wake_irq_i,
    input wire wake_wdt_i,
    input wire wdt_timeout_i,
    input wire reset_instr_i,
    input wire stack_over_i,
    input wire stack_under_i,
    input wire sw_pullup_i,
    input wire pready_o,
    input wire core_reset_o,
    input wire bor_enable_o,
    input wire gpio_in_o,
    input wire pullup_en_o,
    input wire [14:0] pc_load_o,
    input wire pc_load_valid_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Pin function decode, config is static
    wire pin_fn = ext_reset_pin_enable_i | low_voltage_prog_enable_i;
    a_pin_holds: assert property ((pin_fn && !ext_reset_pin_i)[*8] |-> ##[0:4] core_reset_o)
        else $error("pin held low did not reset core");
    a_gpio_quiet: assert property (pin_fn[*3] |-> !gpio_in_o)
        else $error("gpio shows pin while reset function on");
    a_pullup_sel: assert property ((!pin_fn && $stable(sw_pullup_i))[*3] |-> pullup_en_o == sw_pullup_i)
        else $error("pull-up not under software control");
    a_det_off: assert property ((brownout_mode_cfg_i == 2'b00)[*3] |-> !bor_enable_o)
        else $error("detector on in off mode");
    a_det_on: assert property ((brownout_mode_cfg_i == 2'b11)[*3] |-> bor_enable_o)
        else $error("detector off in always-on mode");
    a_det_awake: assert property ((brownout_mode_cfg_i == 2'b10 && !sleep_i)[*3] |-> bor_enable_o)
        else $error("detector off while awake");
    a_det_sleep: assert property ((brownout_mode_cfg_i == 2'b10 && sleep_i && !wake_irq_i && !wake_wdt_i)[*3]
        |-> !bor_enable_o)
        else $error("detector on during sleep");
    a_start_ready: assert property ($fell(core_reset_o) && brownout_mode_cfg_i[1]
        |-> $past(bor_ready_i) && !$past(bor_low_i))
        else $error("start-up did not wait for detector");
    a_start_osc: assert property ($fell(core_reset_o) |-> $past(ost_done_i))
        else $error("start-up before oscillator ready");
    a_start_pc: assert property ($fell(core_reset_o) |-> pc_load_valid_o && pc_load_o == 15'h0000)
        else $error("start-up without reset vector");
    a_wd_reset: assert property (wdt_timeout_i && !core_reset_o |-> ##[1:3] core_reset_o)
        else $error("watchdog time-out did not reset");
    a_instr_reset: assert property (reset_instr_i && !core_reset_o |-> ##[1:3] core_reset_o)
        else $error("reset instruction did not reset");
    a_stack_reset: assert property (stack_fault_reset_enable_i && (stack_over_i || stack_under_i) && !core_reset_o
        |-> ##[1:3] core_reset_o)
        else $error("stack fault did not reset");
    a_power_reset: assert property (por_i || prog_exit_i |-> ##[1:3] core_reset_o)
        else $error("power-on event did not reset");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("bus ready longer than one cycle");
endmodule

bind rss_top rss_top_props #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .FILT_CYCLES(FILT_CYCLES)) rss_top_props_i (.*);

/* rss_far_model.sv */
// Far side of the sequencer: reset pin with weak pull-up, supply monitor, oscillator timer.
// Assumes the bench commands pin, power and supply events.
`timescale 1ns/1ps
module rss_far_model #(
    parameter READY_DLY = 60,
    parameter OST_CYCLES = 10
) (
    input wire ref_clk_i,
    input wire det_enable_i,
    input wire pin_low_i,
    input wire power_on_i,
    input wire supply_low_i,
    output wire pin_o,
    output wire pwr_on_o,
    output wire sup_low_o,
    output reg det_ready_o,
    output reg osc_done_o
);
    integer rdy_cnt = 0;
    integer ost_cnt = 0;
    initial
    begin
        det_ready_o = 1'b0;
        osc_done_o = 1'b0;
    end
    // Released pin floats high through the pull-up
    assign pin_o = !pin_low_i;
    assign pwr_on_o = power_on_i;
    assign sup_low_o = supply_low_i;
    // Detector settles only after a long enabled stretch
    always @(posedge ref_clk_i)
    begin
        rdy_cnt <= det_enable_i ? ((rdy_cnt < READY_DLY) ? rdy_cnt + 1 : rdy_cnt) : 0;
        det_ready_o <= det_enable_i && (rdy_cnt >= READY_DLY);
    end
    // Oscillator timer restarts on power-on, never looks at the pin
    always @(posedge ref_clk_i)
    begin
        ost_cnt <= power_on_i ? 0 : ((ost_cnt < OST_CYCLES) ? ost_cnt + 1 : ost_cnt);
        osc_done_o <= (ost_cnt >= OST_CYCLES) && !power_on_i;
    end
endmodule

/* rss_top_bench.sv */
// Self-checking bench of the reset sequencer: APB tasks, far-side model, sequenced checks.
// Assumes rss_top, rss_far_model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_top_bench;
    localparam TIMER_LEN = 20;
    localparam RDY = 60;
    reg clk = 0, rst_n = 0, pin_en = 1, low_voltage_prog_enable = 0, pin_low = 0, pwr_on = 0, sup_low = 0, prog_exit = 0;
    reg [1:0] mode = 2'b11;
    reg sleep = 0, wk_irq = 0, wd_trip = 0, rinstr = 0, s_ovf = 0, s_unf = 0, pull = 0, stk_en = 1, powerup_timer_n = 0;
    reg psel = 0, pen = 0, pwr = 0, err, seen;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000, rd;
    reg [7:0] xp [0:4] = '{8'h0B, 8'h8F, 8'h4F, 8'h0F, 8'h0C};
    wire [31:0] prdata;
    wire [14:0] pc;
    wire pready, pslverr, core_rst, det_en, hold, gpio, pull_en, pc_vld, pin, por, slow, rdy, ost;
    integer error_cnt = 0, checks = 0, cyc = 0, n, i;

    rss_top #(.POWERUP_TIMER_CYCLES(TIMER_LEN), .FILT_CYCLES(8)) rss_top_i (.ref_clk_i(clk), .rst_n_i(rst_n),
        .brownout_mode_cfg_i(mode), .ext_reset_pin_enable_i(pin_en), .low_voltage_prog_enable_i(low_voltage_prog_enable),
        .stack_fault_reset_enable_i(stk_en), .powerup_timer_enable_n_i(powerup_timer_n), .ext_reset_pin_i(pin), .por_i(por),
        .bor_low_i(slow), .bor_ready_i(rdy), .ost_done_i(ost), .prog_exit_i(prog_exit), .sleep_i(sleep),
        .wake_irq_i(wk_irq), .wake_wdt_i(1'b0), .global_irq_enable_i(1'b1), .wdt_timeout_i(wd_trip),
        .reset_instr_i(rinstr), .stack_over_i(s_ovf), .stack_under_i(s_unf), .sw_pullup_i(pull), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .core_reset_o(core_rst), .bor_enable_o(det_en), .wake_hold_o(hold), .gpio_in_o(gpio),
        .pullup_en_o(pull_en), .pc_load_o(pc), .pc_load_valid_o(pc_vld));
    rss_far_model #(.READY_DLY(RDY), .OST_CYCLES(10)) rss_far_model_i (.ref_clk_i(clk), .det_enable_i(det_en),
        .pin_low_i(pin_low), .power_on_i(pwr_on), .supply_low_i(sup_low), .pin_o(pin), .pwr_on_o(por),
        .sup_low_o(slow), .det_ready_o(rdy), .osc_done_o(ost));

    // ----------------------------------------
    // Clock, timeout and tasks
    // ----------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far above the sum of all waits
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    task chk(input [31:0] seen_v, input [31:0] exp_v);
    begin
        checks = checks + 1;
        if (seen_v !== exp_v)
        begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    end
    endtask
    // Setup, then access held until ready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    end
    endtask
    task rdchk(input [11:0] a, input [7:0] e);
    begin
        apb(0, a, 32'h00000000);
        chk(rd, {24'h000000, e});
    end
    endtask
    // Counts cycles until the core leaves reset
    task wait_run;
    begin
        n = 0;
        while (core_rst !== 1'b0)
        begin
            n = n + 1;
            @(posedge clk);
        end
    end
    endtask
    task boot(input [1:0] m, input pe);
    begin
        @(posedge clk);
        rst_n <= 0;
        mode <= m;
        pin_en <= pe;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        wait_run;
    end
    endtask
    task finish_test;
    begin
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        boot(2'b11, 1'b1);
        chk(n >= TIMER_LEN, 1);
        rdchk(`RSS_OFF_BROWNOUT_CONTROL, 8'h81);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'h0C);
        rdchk(`RSS_OFF_STATUS, 8'h1A);
        apb(1, `RSS_OFF_BROWNOUT_CONTROL, 32'hFFFFFFFF);
        rdchk(`RSS_OFF_BROWNOUT_CONTROL, 8'h81);
        apb(1, `RSS_OFF_BROWNOUT_CONTROL, 32'h00000000);
        rdchk(`RSS_OFF_BROWNOUT_CONTROL, 8'h01);
        chk(det_en, 1);
        apb(0, 12'h020, 32'h00000000);
        chk(err, 1);
        chk(rd, 32'h00000000);
        apb(1, `RSS_OFF_POWER_CONTROL, 32'h000000FF);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'hCF);
        // Short glitch first, then a real pin reset
        pin_low <= 1;
        repeat (3) @(posedge clk);
        pin_low <= 0;
        seen = 0;
        repeat (15) @(posedge clk) seen = seen | core_rst;
        chk(seen, 0);
        pin_low <= 1;
        repeat (20) @(posedge clk);
        chk(core_rst, 1);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'hC7);
        pin_low <= 0;
        wait_run;
        chk(n <= 14, 1);
        // Each reset event against a known flag image
        for (i = 0; i < 5; i = i + 1)
        begin
            apb(1, `RSS_OFF_POWER_CONTROL, 32'h0000000F);
            case (i)
                0: rinstr <= 1;
                1: s_ovf <= 1;
                2: s_unf <= 1;
                3: wd_trip <= 1;
                default: prog_exit <= 1;
            endcase
            @(posedge clk);
            {rinstr, s_ovf, s_unf, wd_trip, prog_exit} <= 5'h00;
            while (core_rst !== 1'b1) @(posedge clk);
            wait_run;
            rdchk(`RSS_OFF_POWER_CONTROL, xp[i]);
            if (i > 2)
                rdchk(`RSS_OFF_STATUS, (i == 3) ? 8'h0A : 8'h1A);
        end
        // Stack fault with its reset disabled leaves core and flags alone
        stk_en <= 0;
        s_ovf <= 1;
        @(posedge clk);
        s_ovf <= 0;
        repeat (3) @(posedge clk);
        chk(core_rst, 0);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'h0C);
        stk_en <= 1;
        apb(1, `RSS_OFF_POWER_CONTROL, 32'h0000000F);
        sup_low <= 1;
        repeat (3) @(posedge clk);
        sup_low <= 0;
        while (core_rst !== 1'b1) @(posedge clk);
        wait_run;
        chk(n >= TIMER_LEN, 1);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'h0E);
        rdchk(`RSS_OFF_STATUS, 8'h1A);
        // Fresh power-on restarts the timers and rewrites the flags
        pwr_on <= 1;
        @(posedge clk);
        pwr_on <= 0;
        while (core_rst !== 1'b1) @(posedge clk);
        wait_run;
        chk(n >= TIMER_LEN, 1);
        rdchk(`RSS_OFF_POWER_CONTROL, 8'h0C);
        boot(2'b01, 1'b1);
        chk(n < RDY, 1);
        apb(1, `RSS_OFF_BROWNOUT_CONTROL, 32'h00000000);
        repeat (3) @(posedge clk);
        chk(det_en, 0);
        rdchk(`RSS_OFF_BROWNOUT_CONTROL, 8'h00);
        apb(1, `RSS_OFF_BROWNOUT_CONTROL, 32'h00000080);
        sleep <= 1;
        repeat (RDY + 6) @(posedge clk);
        chk(det_en, 1);
        sleep <= 0;
        rdchk(`RSS_OFF_BROWNOUT_CONTROL, 8'h81);
        // Power-up timer switched off: start-up follows release at once
        powerup_timer_n <= 1;
        boot(2'b00, 1'b0);
        chk(n < RDY, 1);
        chk(n < TIMER_LEN, 1);
        powerup_timer_n <= 0;
        pull <= 1;
        pin_low <= 1;
        repeat (20) @(posedge clk);
        chk({core_rst, gpio, pull_en}, 3'b001);
        pull <= 0;
        pin_low <= 0;
        repeat (4) @(posedge clk);
        chk({gpio, pull_en}, 2'b10);
        // Interrupt wake in mode 10 must wait for the detector
        boot(2'b10, 1'b1);
        sleep <= 1;
        repeat (8) @(posedge clk);
        chk(det_en, 0);
        wk_irq <= 1;
        n = 0;
        seen = 0;
        while (pc_vld !== 1'b1)
        begin
            seen = seen | hold;
            n = n + 1;
            @(posedge clk);
        end
        chk(pc, 15'h0004);
        chk({seen, n >= RDY}, 2'b11);
        sleep <= 0;
        wk_irq <= 0;
        repeat (4) @(posedge clk);
        finish_test;
    end
endmodule
